// *** verilog/rcp_top.sv ***
// Purpose: Reset cause recording, key-protected cause clearing and reset pin function control
// Assumes: rst is the power-on reset; event inputs are synchronous one-cycle or level signals on mclk
// Notes: Internal factor resets keep the cause flags; pin and power-on resets clear them
`timescale 1ns/1ns
module rcp_top
(
  // Clock and power-on reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Internal reset factors and trim load status
  input wire logic flash_rd,
  input wire logic flash_wr,
  input wire logic wdt_ovf,
  input wire logic vdet_hit,
  input wire logic trim_broken,
  input wire logic trim_load_done,
  input wire logic trim_load_ok,
  // Reset pin
  input wire logic rst_pin_in,
  output logic port_in,
  output logic pin_is_port,
  // Reset requests
  output logic int_reset,
  output logic ext_reset
);
  typedef struct packed
  {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [rcp_pkg::CAUSE_W-1:0] cause;
    logic reset_pin_disable;
    logic pin_port;
    logic [1:0] osc;
    logic fstby;
    rcp_pkg::rcp_state_e st;
    logic [rcp_pkg::CNT_W-1:0] cnt;
    logic int_rst;
    logic ext_rst;
    logic port_in;
    logic key_wr;
    logic [7:0] key_data;
  } rcp_top_s;

  rcp_top_s s_r;
  rcp_top_s s_nxt;
  logic pin_q;
  logic [rcp_pkg::CAUSE_W-1:0] ev;

  rcp_key_if kif ();

  rcp_key_unit u_key
  (
    .mclk(mclk),
    .rst(rst),
    .kif(kif.unit)
  );

  rcp_sync #(.W(1), .RST_VAL(1'b1)) u_pin_sync
  (
    .mclk(mclk),
    .rst(rst),
    .d(rst_pin_in),
    .q(pin_q)
  );

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == rcp_pkg::OFF_CAUSE) || (a == rcp_pkg::OFF_SYS3) || (a == rcp_pkg::OFF_KEY) ||
                (a == rcp_pkg::OFF_OSC) || (a == rcp_pkg::OFF_FLASH);
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a, input rcp_top_s s);
    read_word = 32'h0000_0000;
    case (a)
      rcp_pkg::OFF_CAUSE: read_word[rcp_pkg::CAUSE_W-1:0] = s.cause;
      rcp_pkg::OFF_SYS3:
      begin
        read_word[rcp_pkg::B_RESET_PIN_DISABLE] = s.reset_pin_disable;
        read_word[rcp_pkg::B_PINPORT] = s.pin_port;
      end
      rcp_pkg::OFF_OSC: read_word[1:0] = s.osc;
      rcp_pkg::OFF_FLASH: read_word[0] = s.fstby;
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  // Factor vector lines up with the cause bits so it can be ORed in directly
  always_comb
  begin
    ev = '0;
    ev[rcp_pkg::B_FSTBY] = s_r.fstby && (flash_rd || flash_wr);
    ev[rcp_pkg::B_SYSCLK] = (s_r.osc == rcp_pkg::OSC_DEADLOCK);
    ev[rcp_pkg::B_WDT] = wdt_ovf;
    ev[rcp_pkg::B_VDET] = vdet_hit;
    ev[rcp_pkg::B_TRIMRST] = trim_broken;
  end

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.key_wr = 1'b0;
    s_nxt.port_in = pin_q;

    // Two-cycle access: pready rises in the second access cycle
    s_nxt.pready = psel && penable && !s_r.pready;
    if (psel && penable && !s_r.pready)
    begin
      s_nxt.pslverr = !is_mapped(paddr);
      s_nxt.prdata = pwrite ? 32'h0000_0000 : read_word(paddr, s_r);
    end

    if (psel && penable && s_r.pready && pwrite)
    begin
      case (paddr)
        rcp_pkg::OFF_CAUSE: s_nxt.cause[rcp_pkg::B_CAUSE_CLEAR_FLAG] = pwdata[rcp_pkg::B_CAUSE_CLEAR_FLAG];
        rcp_pkg::OFF_SYS3: s_nxt.reset_pin_disable = pwdata[rcp_pkg::B_RESET_PIN_DISABLE];
        rcp_pkg::OFF_KEY:
        begin
          s_nxt.key_wr = 1'b1;
          s_nxt.key_data = pwdata[7:0];
        end
        rcp_pkg::OFF_OSC: s_nxt.osc = pwdata[1:0];
        rcp_pkg::OFF_FLASH: s_nxt.fstby = pwdata[0];
        default: s_nxt.key_wr = 1'b0;
      endcase
    end

    // A clear key without the clear flag armed does nothing
    if (kif.fire_clear && s_r.cause[rcp_pkg::B_CAUSE_CLEAR_FLAG])
      s_nxt.cause = rcp_pkg::CAUSE_RST;
    if (kif.fire_pin)
      s_nxt.pin_port = s_r.reset_pin_disable;

    // Placed after the clear so a simultaneous fault still lands
    if (trim_load_done && !trim_load_ok)
      s_nxt.cause[rcp_pkg::B_TRIMF] = 1'b1;

    case (s_r.st)
      rcp_pkg::RCP_RUN:
      begin
        if (!s_r.pin_port && !pin_q)
        begin
          if (s_r.cnt == rcp_pkg::EXT_RST_CYC - 10'h001)
          begin
            // Pin reset reinitialises the registers except pin_port, the cause flags included
            s_nxt.cause = rcp_pkg::CAUSE_RST;
            s_nxt.reset_pin_disable = 1'b0;
            s_nxt.osc = rcp_pkg::OSC_RST;
            s_nxt.fstby = 1'b0;
            s_nxt.ext_rst = 1'b1;
            s_nxt.st = rcp_pkg::RCP_EXT_RST;
          end
          else
            s_nxt.cnt = s_r.cnt + 10'h001;
        end
        else
        begin
          s_nxt.cnt = '0;
          if (|ev)
          begin
            // Internal reset keeps the recorded causes and adds the new one
            s_nxt.cause = s_nxt.cause | ev;
            s_nxt.osc = rcp_pkg::OSC_RST;
            s_nxt.fstby = 1'b0;
            s_nxt.int_rst = 1'b1;
            s_nxt.cnt = rcp_pkg::INT_RST_CYC - 10'h001;
            s_nxt.st = rcp_pkg::RCP_INT_RST;
          end
        end
      end
      rcp_pkg::RCP_INT_RST:
      begin
        // Further factors are ignored while the reset is asserted
        if (s_r.cnt == '0)
        begin
          s_nxt.int_rst = 1'b0;
          s_nxt.st = rcp_pkg::RCP_RUN;
        end
        else
          s_nxt.cnt = s_r.cnt - 10'h001;
      end
      rcp_pkg::RCP_EXT_RST:
      begin
        if (pin_q)
        begin
          s_nxt.ext_rst = 1'b0;
          s_nxt.cnt = '0;
          s_nxt.st = rcp_pkg::RCP_RUN;
        end
      end
      default:
      begin
        s_nxt.st = rcp_pkg::RCP_RUN;
        s_nxt.cnt = '0;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_r.pready <= 1'b0;
      s_r.pslverr <= 1'b0;
      s_r.prdata <= 32'h0000_0000;
      s_r.cause <= rcp_pkg::CAUSE_RST;
      s_r.reset_pin_disable <= 1'b0;
      s_r.pin_port <= 1'b0;
      s_r.osc <= rcp_pkg::OSC_RST;
      s_r.fstby <= 1'b0;
      s_r.st <= rcp_pkg::RCP_RUN;
      s_r.cnt <= '0;
      s_r.int_rst <= 1'b0;
      s_r.ext_rst <= 1'b0;
      s_r.port_in <= 1'b1;
      s_r.key_wr <= 1'b0;
      s_r.key_data <= 8'h00;
    end
    else
      s_r <= s_nxt;
  end

  assign kif.key_wr = s_r.key_wr;
  assign kif.key_data = s_r.key_data;

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign port_in = s_r.port_in;
  assign pin_is_port = s_r.pin_port;
  assign int_reset = s_r.int_rst;
  assign ext_reset = s_r.ext_rst;
endmodule

// *** verilog/rcp_pkg.sv ***
// Purpose: Shared constants and types for the reset cause and pin control block
// Assumes: 100 MHz mclk, APB register access with 32-bit data
// Notes: All offsets are byte addresses of aligned words
package rcp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CAUSE = 8'h00;
  localparam logic [7:0] OFF_SYS3 = 8'h04;
  localparam logic [7:0] OFF_KEY = 8'h08;
  localparam logic [7:0] OFF_OSC = 8'h0c;
  localparam logic [7:0] OFF_FLASH = 8'h10;

  // Bit positions inside reset_cause_status
  localparam int B_CAUSE_CLEAR_FLAG = 0;
  localparam int B_TRIMF = 1;
  localparam int B_VDET = 2;
  localparam int B_WDT = 3;
  localparam int B_SYSCLK = 4;
  localparam int B_TRIMRST = 5;
  localparam int B_FSTBY = 6;
  localparam int CAUSE_W = 7;

  // Bit positions inside system_control_three
  localparam int B_RESET_PIN_DISABLE = 0;
  localparam int B_PINPORT = 1;

  // Key codes
  localparam logic [7:0] KEY_CLEAR = 8'h71;
  localparam logic [7:0] KEY_PIN = 8'hb2;

  // Values after reset, and the oscillator setting that forces a reset
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 7'h00;
  localparam logic [1:0] OSC_RST = 2'h1;
  localparam logic [1:0] OSC_DEADLOCK = 2'h0;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int EXT_RST_MIN_NS = 5000;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] EXT_RST_CYC = CNT_W'((EXT_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] INT_RST_CYC = 10'h010;

  typedef enum logic [1:0] {RCP_RUN, RCP_INT_RST, RCP_EXT_RST} rcp_state_e;
endpackage

// *** verilog/rcp_key_if.sv ***
// Purpose: Carries key register writes to the key checker and its enables back
// Assumes: All signals on mclk
// Notes: fire_clear and fire_pin are one-cycle pulses
`timescale 1ns/1ns
interface rcp_key_if;
  logic key_wr;
  logic [7:0] key_data;
  logic fire_clear;
  logic fire_pin;
  modport host (output key_wr, output key_data, input fire_clear, input fire_pin);
  modport unit (input key_wr, input key_data, output fire_clear, output fire_pin);
endinterface

// *** verilog/rcp_key_unit.sv ***
// Purpose: Compares key register writes against the two protection codes
// Assumes: key_wr is a one-cycle pulse from the register slave
// Notes: Any other code produces no pulse at all
`timescale 1ns/1ns
module rcp_key_unit
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Key path
  rcp_key_if.unit kif
);
  typedef struct packed
  {
    logic fire_clear;
    logic fire_pin;
  } rcp_key_s;

  rcp_key_s st_r;
  rcp_key_s st_nxt;

  always_comb
  begin
    st_nxt.fire_clear = kif.key_wr && (kif.key_data == rcp_pkg::KEY_CLEAR);
    st_nxt.fire_pin = kif.key_wr && (kif.key_data == rcp_pkg::KEY_PIN);
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign kif.fire_clear = st_r.fire_clear;
  assign kif.fire_pin = st_r.fire_pin;
endmodule

// *** verilog/rcp_sync.sv ***
// Purpose: Two-stage synchroniser for levels from outside the clock domain
// Assumes: Input changes slowly compared with mclk
// Notes: First stage feeds only the second
`timescale 1ns/1ns
module rcp_sync
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed
  {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rcp_sync_s;

  rcp_sync_s st_r;
  rcp_sync_s st_nxt;

  always_comb
  begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  // Idle level high so a released pin never looks like a reset
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      st_r <= {RST_VAL, RST_VAL};
    else
      st_r <= st_nxt;
  end

  assign q = st_r.s2;
endmodule

// *** verification/rcp_pin_src.sv ***
// Purpose: Outside source on the reset pin
// Assumes: Pull-up on the pin
// Notes: Released pin reads high through the pull-up
`timescale 1ns/1ns
module rcp_pin_src
(
  // Request from the bench
  input wire logic drive_low,
  // Pin level
  output logic pin
);
  // Pin sits high from power-up and only goes low on request
  assign pin = ~drive_low;
endmodule

// *** verification/rcp_top_properties.sv ***
// Purpose: Port-level properties of rcp_top
// Assumes: One mclk domain, rst active high
// Notes: Attached by bind below
`timescale 1ns/1ns
module rcp_top_properties
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Factors and pin
  input wire logic wdt_ovf,
  input wire logic vdet_hit,
  input wire logic trim_broken,
  input wire logic port_in,
  input wire logic pin_is_port,
  input wire logic int_reset,
  input wire logic ext_reset
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic pin_key;
  assign pin_key = pready && pwrite && paddr == rcp_pkg::OFF_KEY && pwdata[7:0] == rcp_pkg::KEY_PIN;
  sequence hold8;
    int_reset [*8];
  endsequence
  a_ready_next: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_slverr_map: assert property (pready |-> pslverr == (paddr > rcp_pkg::OFF_FLASH || paddr[1:0] != 2'h0))
    else $error("pslverr wrong");
  a_int_len: assert property ($rose(int_reset) |-> hold8 ##1 hold8 ##1 !int_reset)
    else $error("int_reset length");
  a_factor_reset: assert property ((wdt_ovf || vdet_hit || trim_broken) && !int_reset && !ext_reset
    |=> $rose(int_reset)) else $error("factor ignored");
  a_key_reads_zero: assert property (pready && !pwrite && paddr == rcp_pkg::OFF_KEY |-> prdata == 0)
    else $error("key reg read");
  a_pin_by_key: assert property ($changed(pin_is_port) |-> $past(pin_key, 2) || $past(pin_key, 3))
    else $error("pin mode change");
  a_port_no_ext: assert property (pin_is_port |=> !$rose(ext_reset)) else $error("port reset");
  a_ext_rise: assert property ($rose(ext_reset) |-> !pin_is_port && !$past(port_in))
    else $error("ext_reset cause");
  // Pin high and the end of ext_reset land on the same edge, so look one sample back
  a_ext_end: assert property ($rose(port_in) && $past(ext_reset) |-> ##[0:3] !ext_reset)
    else $error("ext_reset stuck");
  a_ext_fall: assert property ($fell(ext_reset) |-> port_in) else $error("ext_reset early end");
endmodule
bind rcp_top rcp_top_properties u_props (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .wdt_ovf, .vdet_hit, .trim_broken, .port_in, .pin_is_port, .int_reset, .ext_reset);

// *** verification/rcp_top_tb.sv ***
// Purpose: Self-checking bench for rcp_top
// Assumes: APB answers are awaited under a bound
// Notes: Factor inputs are one-cycle pulses
`timescale 1ns/1ns
module rcp_top_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trim_ok = 1'b1, drive_low = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, want;
  logic [5:0] fac = 6'h00;
  logic [31:0] prdata;
  logic pready, pslverr, pin, port_in, pin_is_port, int_reset, ext_reset;
  int failures = 0, checked = 0;
  int bitpos [6] = '{6, 6, 3, 2, 5, 4};
  always #5 mclk = ~mclk;
  rcp_pin_src u_src (.drive_low, .pin);
  rcp_top DUT (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .flash_rd(fac[0]), .flash_wr(fac[1]), .wdt_ovf(fac[2]), .vdet_hit(fac[3]), .trim_broken(fac[4]),
    .trim_load_done(fac[5]), .trim_load_ok(trim_ok), .rst_pin_in(pin), .port_in, .pin_is_port,
    .int_reset, .ext_reset);
  task complete_run;
    $display("Mismatches %0d of %0d checks", failures, checked);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp_v);
    checked++;
    if (seen !== exp_v)
    begin
      failures++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp_v);
    end
  endtask
  // Request is held until the edge that samples pready high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready === 1'b1)
    begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
    else
    begin
      failures++;
      complete_run;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp_v);
    apb(1'b0, a, 32'h0);
    chk(rd, exp_v);
  endtask
  task pulse(input int b);
    @(posedge mclk);
    fac[b] <= 1'b1;
    @(posedge mclk);
    fac[b] <= 1'b0;
  endtask
  // Internal reset lasts 16 cycles, so 20 covers it
  task settle;
    repeat (20) @(posedge mclk);
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk(port_in, 32'h1);
    chk(pin_is_port, 32'h0);
    rdc(rcp_pkg::OFF_CAUSE, 32'(rcp_pkg::CAUSE_RST));
    rdc(rcp_pkg::OFF_SYS3, 32'h0);
    rdc(rcp_pkg::OFF_OSC, 32'(rcp_pkg::OSC_RST));
    rdc(rcp_pkg::OFF_KEY, 32'h0);
    rdc(8'h20, 32'h0);
    chk(err, 32'h1);
    pulse(0);
    settle;
    chk(int_reset, 32'h0);
    trim_ok <= 1'b0;
    pulse(5);
    trim_ok <= 1'b1;
    want = 32'h2;
    rdc(rcp_pkg::OFF_CAUSE, want);
    for (int i = 0; i < 6; i++)
    begin
      if (i < 2)
        wr(rcp_pkg::OFF_FLASH, 32'h1);
      if (i == 5)
        wr(rcp_pkg::OFF_OSC, 32'(rcp_pkg::OSC_DEADLOCK));
      else
        pulse(i);
      repeat (2) @(posedge mclk);
      chk(int_reset, 32'h1);
      settle;
      want[bitpos[i]] = 1'b1;
      rdc(rcp_pkg::OFF_CAUSE, want);
    end
    rdc(rcp_pkg::OFF_OSC, 32'(rcp_pkg::OSC_RST));
    wr(rcp_pkg::OFF_CAUSE, 32'h1);
    wr(rcp_pkg::OFF_KEY, 32'h55);
    rdc(rcp_pkg::OFF_CAUSE, want | 32'h1);
    wr(rcp_pkg::OFF_KEY, 32'(rcp_pkg::KEY_CLEAR));
    rdc(rcp_pkg::OFF_CAUSE, 32'h0);
    pulse(2);
    settle;
    wr(rcp_pkg::OFF_KEY, 32'(rcp_pkg::KEY_CLEAR));
    rdc(rcp_pkg::OFF_CAUSE, 32'h8);
    // Pin stays high while its function is switched
    wr(rcp_pkg::OFF_SYS3, 32'h1);
    wr(rcp_pkg::OFF_KEY, 32'h55);
    rdc(rcp_pkg::OFF_SYS3, 32'h1);
    wr(rcp_pkg::OFF_KEY, 32'(rcp_pkg::KEY_PIN));
    rdc(rcp_pkg::OFF_SYS3, 32'h3);
    drive_low <= 1'b1;
    repeat (600) @(posedge mclk);
    chk(ext_reset, 32'h0);
    chk(port_in, 32'h0);
    rdc(rcp_pkg::OFF_SYS3, 32'h3);
    drive_low <= 1'b0;
    repeat (5) @(posedge mclk);
    wr(rcp_pkg::OFF_SYS3, 32'h0);
    wr(rcp_pkg::OFF_KEY, 32'(rcp_pkg::KEY_PIN));
    rdc(rcp_pkg::OFF_SYS3, 32'h0);
    drive_low <= 1'b1;
    repeat (520) @(posedge mclk);
    chk(ext_reset, 32'h1);
    drive_low <= 1'b0;
    repeat (10) @(posedge mclk);
    chk(ext_reset, 32'h0);
    rdc(rcp_pkg::OFF_CAUSE, 32'h0);
    complete_run;
  end
endmodule
